// ---- hw/vlqm_pkg.sv ----
package vlqm_pkg;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [5:0] VLQM_IDX_VAR_CTRL = 6'h1A;
    localparam logic [5:0] VLQM_IDX_VAR_DATA = 6'h1B;
    localparam logic [5:0] VLQM_IDX_LQM_CTRL = 6'h1D;
    localparam logic [5:0] VLQM_IDX_PCS_CFG = 6'h1F;
    localparam logic [5:0] VLQM_IDX_INT_CTRL = 6'h20;
    localparam logic [5:0] VLQM_IDX_THR_BASE = 6'h22;
    localparam logic [5:0] VLQM_THR_COUNT = 6'h0A;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned VLQM_VC_READY_BIT = 15;
    localparam int unsigned VLQM_VC_FREEZE_BIT = 3;
    localparam int unsigned VLQM_VC_TIMER_LSB = 1;
    localparam int unsigned VLQM_VC_ENABLE_BIT = 0;
    localparam int unsigned VLQM_LQ_ENABLE_BIT = 15;
    localparam int unsigned VLQM_LQ_RESTART_LSB = 10;
    localparam int unsigned VLQM_PCS_SIGNAL_DETECT_OPTION_BIT = 8;
    localparam int unsigned VLQM_INT_LQ_ENABLE_BIT = 0;
    localparam int unsigned VLQM_NPARAM = 5;

    // Only the upper five warnings live in this block
    localparam logic [9:0] VLQM_WARN_MASK = 10'h3E0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] VLQM_ZERO16 = 16'h0000;
    localparam logic [15:0] VLQM_THR_HI_RST = 16'hFFFF;
    localparam logic [15:0] VLQM_THR_LO_RST = 16'h0000;
    localparam logic [31:0] VLQM_ZERO32 = 32'h0000_0000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef logic [15:0] vlqm_param_t;

    // Adapted DSP parameters, most significant member is index 4
    typedef struct packed {
        vlqm_param_t freq_control;
        vlqm_param_t freq_offset;
        vlqm_param_t baseline_wander;
        vlqm_param_t digital_gain_control;
        vlqm_param_t equalizer_coefficient_one;
    } vlqm_dsp_t;

    // Variance readout half pointer
    typedef enum logic [1:0] {
        VLQM_RD_LOW = 2'b01,
        VLQM_RD_HIGH = 2'b10
    } vlqm_rd_state_t;

endpackage

// ---- hw/vlqm_top.sv ----
`timescale 1ns/1ps
module vlqm_top
    import vlqm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] var_sum_i,
    input wire logic var_new_i,
    input wire logic link_100_ok_i,
    input wire vlqm_dsp_t dsp_param_i,
    output logic ack_o,
    output logic [31:0] dat_o,
    output logic irq_o,
    output logic var_enable_o,
    output logic [1:0] var_timer_o,
    output logic var_restart_o,
    output logic dsp_restart_o,
    output logic link_drop_o
);

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic ack_reg, req_take, wr_take, rd_take;
    logic [31:0] dat_reg, rdata;
    logic [5:0] idx;
    logic [15:0] wmask, wdat;

    // A request is taken once; ack blocks a second take of the same request
    assign req_take = cyc_i & stb_i & ~ack_reg;
    assign wr_take = req_take & we_i;
    assign rd_take = req_take & ~we_i;
    assign idx = adr_i[7:2];
    assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    assign wdat = dat_i[15:0];

    // Byte-lane merge for the 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nv,
                                            input logic [15:0] m);
        merge16 = (old & ~m) | (nv & m);
    endfunction

    // ************************************************************
    // Register state
    // ************************************************************
    logic [31:0] var_held_reg;
    logic var_ready_reg, var_freeze_reg, var_enable_reg, var_restart_reg;
    logic [1:0] var_timer_reg;
    vlqm_rd_state_t rd_state_reg;
    logic lq_enable_reg, pcs_sd_reg, int_en_reg, irq_reg, armed_reg, dsp_restart_reg, link_drop_reg;
    logic [4:0] lq_restart_reg, trig_prev_reg;
    logic [9:0] warn_reg;
    logic [15:0] vc_wr, lq_wr, thr_reg [10];
    logic var_ctrl_wr, data_rd, lq_read, freeze_rise;

    assign var_ctrl_wr = wr_take & (idx == VLQM_IDX_VAR_CTRL);
    assign data_rd = rd_take & (idx == VLQM_IDX_VAR_DATA);
    assign lq_read = rd_take & (idx == VLQM_IDX_LQM_CTRL);
    assign vc_wr = merge16({8'h00, 4'h0, var_freeze_reg, var_timer_reg, var_enable_reg},
                           wdat, wmask);
    assign lq_wr = merge16({lq_enable_reg, lq_restart_reg, 10'h000}, wdat, wmask);
    assign freeze_rise = var_ctrl_wr & vc_wr[VLQM_VC_FREEZE_BIT] & ~var_freeze_reg;

    // ************************************************************
    // Monitor comparators
    // ************************************************************
    vlqm_param_t [4:0] params;
    logic [9:0] viol, viol_act;
    logic [4:0] param_viol, trig, trig_rise;
    logic monitor_active, any_viol;

    assign params = dsp_param_i;
    // Enable counts only with a valid 100 Mb link
    assign monitor_active = lq_enable_reg & link_100_ok_i;

    // Strict compares: a high threshold at full scale or a low threshold at zero can never be crossed
    generate
        for (genvar k = 0; k < VLQM_NPARAM; k++) begin : g_cmp
            assign viol[2*k+1] = params[k] > thr_reg[2*k+1];
            assign viol[2*k] = params[k] < thr_reg[2*k];
            assign param_viol[k] = viol_act[2*k+1] | viol_act[2*k];
        end
    endgenerate

    assign viol_act = viol & {10{monitor_active}};
    assign any_viol = |viol_act;
    assign trig = param_viol & lq_restart_reg;
    assign trig_rise = trig & ~trig_prev_reg;

    // ************************************************************
    // Wishbone slave
    // ************************************************************
    // Read mux; unmapped addresses read as zero and still ack
    always_comb begin
        logic [5:0] thr_off;
        thr_off = idx - VLQM_IDX_THR_BASE;
        rdata = VLQM_ZERO32;
        case (idx)
            VLQM_IDX_VAR_CTRL: begin
                rdata[VLQM_VC_READY_BIT] = var_ready_reg;
                rdata[VLQM_VC_FREEZE_BIT] = var_freeze_reg;
                rdata[VLQM_VC_TIMER_LSB +: 2] = var_timer_reg;
                rdata[VLQM_VC_ENABLE_BIT] = var_enable_reg;
            end
            VLQM_IDX_VAR_DATA: begin
                rdata[15:0] = (rd_state_reg == VLQM_RD_HIGH) ? var_held_reg[31:16]
                                                              : var_held_reg[15:0];
            end
            VLQM_IDX_LQM_CTRL: begin
                rdata[15:0] = {lq_enable_reg, lq_restart_reg, warn_reg & VLQM_WARN_MASK};
            end
            VLQM_IDX_PCS_CFG: begin
                rdata[VLQM_PCS_SIGNAL_DETECT_OPTION_BIT] = pcs_sd_reg;
            end
            VLQM_IDX_INT_CTRL: begin
                rdata[VLQM_INT_LQ_ENABLE_BIT] = int_en_reg;
            end
            default: begin
                if (thr_off < VLQM_THR_COUNT) begin
                    rdata[15:0] = thr_reg[thr_off[3:0]];
                end
            end
        endcase
    end

    // Single-cycle answer: ack and data one edge after the take
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= VLQM_ZERO32;
        end else begin
            ack_reg <= req_take;
            dat_reg <= rd_take ? rdata : VLQM_ZERO32;
        end
    end

    // ************************************************************
    // Variance readout
    // ************************************************************
    // Capture a fresh sum when enabled and not frozen; a new sum beats a clear by reads
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            var_held_reg <= VLQM_ZERO32;
            var_ready_reg <= 1'b0;
        end else if (var_new_i & var_enable_reg & ~var_freeze_reg) begin
            var_held_reg <= var_sum_i;
            var_ready_reg <= 1'b1;
        end else if (data_rd & (rd_state_reg == VLQM_RD_HIGH)) begin
            var_ready_reg <= 1'b0;
        end
    end

    // Half pointer; setting freeze always restarts at the low half
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_state_reg <= VLQM_RD_LOW;
        end else if (freeze_rise) begin
            rd_state_reg <= VLQM_RD_LOW;
        end else if (data_rd) begin
            case (rd_state_reg)
                VLQM_RD_LOW: rd_state_reg <= VLQM_RD_HIGH;
                VLQM_RD_HIGH: rd_state_reg <= VLQM_RD_LOW;
                default: rd_state_reg <= VLQM_RD_LOW;
            endcase
        end
    end

    // Control register; the restart pulse lets the timer reload its period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            var_freeze_reg <= 1'b0;
            var_timer_reg <= 2'h0;
            var_enable_reg <= 1'b0;
            var_restart_reg <= 1'b0;
        end else begin
            var_restart_reg <= var_ctrl_wr;
            if (var_ctrl_wr) begin
                var_freeze_reg <= vc_wr[VLQM_VC_FREEZE_BIT];
                var_timer_reg <= vc_wr[VLQM_VC_TIMER_LSB +: 2];
                var_enable_reg <= vc_wr[VLQM_VC_ENABLE_BIT];
            end else if (data_rd & (rd_state_reg == VLQM_RD_HIGH)) begin
                var_freeze_reg <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Link quality monitor
    // ************************************************************
    // Controls, option bit, interrupt enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lq_enable_reg <= 1'b0;
            lq_restart_reg <= 5'h00;
            pcs_sd_reg <= 1'b0;
            int_en_reg <= 1'b0;
        end else if (wr_take) begin
            if (idx == VLQM_IDX_LQM_CTRL) begin
                lq_enable_reg <= lq_wr[VLQM_LQ_ENABLE_BIT];
                lq_restart_reg <= lq_wr[VLQM_LQ_RESTART_LSB +: 5];
            end
            if ((idx == VLQM_IDX_PCS_CFG) & sel_i[1]) begin
                pcs_sd_reg <= wdat[VLQM_PCS_SIGNAL_DETECT_OPTION_BIT];
            end
            if ((idx == VLQM_IDX_INT_CTRL) & sel_i[0]) begin
                int_en_reg <= wdat[VLQM_INT_LQ_ENABLE_BIT];
            end
        end
    end

    // Thresholds, one register per bound; reset to full scale (high) and zero (low) leaves them off
    generate
        for (genvar i = 0; i < 10; i++) begin : g_thr
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    thr_reg[i] <= (i % 2 == 1) ? VLQM_THR_HI_RST : VLQM_THR_LO_RST;
                end else if (wr_take & (idx == VLQM_IDX_THR_BASE + 6'(i))) begin
                    thr_reg[i] <= merge16(thr_reg[i], wdat, wmask);
                end
            end
        end
    endgenerate

    // Sticky warnings, cleared by a read; a violation in that cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            warn_reg <= 10'h000;
        end else begin
            warn_reg <= ((lq_read ? 10'h000 : warn_reg) | viol_act) & VLQM_WARN_MASK;
        end
    end

    // Interrupt fires once per arming; a monitor read re-arms it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_reg <= 1'b0;
            armed_reg <= 1'b1;
        end else if (~int_en_reg) begin
            irq_reg <= 1'b0;
            armed_reg <= armed_reg | lq_read;
        end else if (lq_read) begin
            irq_reg <= any_viol;
            armed_reg <= ~any_viol;
        end else if (armed_reg & any_viol) begin
            irq_reg <= 1'b1;
            armed_reg <= 1'b0;
        end
    end

    // Restart on a new qualified violation; a held fault restarts only once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_prev_reg <= 5'h00;
            dsp_restart_reg <= 1'b0;
            link_drop_reg <= 1'b0;
        end else begin
            trig_prev_reg <= trig;
            dsp_restart_reg <= |trig_rise;
            link_drop_reg <= (|trig_rise) & ~pcs_sd_reg;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;
    assign irq_o = irq_reg;
    assign var_enable_o = var_enable_reg;
    assign var_timer_o = var_timer_reg;
    assign var_restart_o = var_restart_reg;
    assign dsp_restart_o = dsp_restart_reg;
    assign link_drop_o = link_drop_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence low_read_s;
        data_rd && rd_state_reg == VLQM_RD_LOW;
    endsequence
    sequence high_read_s;
        data_rd && rd_state_reg == VLQM_RD_HIGH;
    endsequence

    freeze_hold_a: assert property (var_freeze_reg |=> $stable(var_held_reg))
        else $error("variance sum changed while frozen");
    low_half_a: assert property (low_read_s |=> ack_o
        && dat_o == {16'h0000, $past(var_held_reg[15:0])})
        else $error("first data read did not return low half");
    pair_read_a: assert property (low_read_s ##1 (!req_take [*2] ##1 high_read_s)
        |=> dat_o == {16'h0000, $past(var_held_reg[31:16])})
        else $error("second data read did not return high half");
    auto_clear_a: assert property ((high_read_s and !var_ctrl_wr) |=> !var_freeze_reg
        && (!var_ready_reg || $past(var_new_i)))
        else $error("ready or freeze not cleared after two reads");
    rearm_low_a: assert property (freeze_rise |=> rd_state_reg == VLQM_RD_LOW)
        else $error("freeze did not restart at low half");
    link_gate_a: assert property (!link_100_ok_i && !lq_read |=> $stable(warn_reg))
        else $error("warning set without a 100 Mb link");
    thr_off_a: assert property (thr_reg[9] == VLQM_THR_HI_RST |-> !viol[9])
        else $error("full-scale threshold flagged");
    irq_raise_a: assert property (int_en_reg && armed_reg && any_viol && !lq_read
        |=> irq_o ##1 (irq_o || $past(lq_read) || !$past(int_en_reg)))
        else $error("violation did not raise interrupt");
    read_clear_a: assert property (lq_read && !any_viol |=> warn_reg == 10'h000
        && !irq_o && armed_reg)
        else $error("monitor read did not clear and re-arm");
    warn_set_a: assert property (viol_act[9] |=> warn_reg[9])
        else $error("frequency control high warning not set");
    drop_link_a: assert property ((|trig_rise) |=> dsp_restart_o
        && link_drop_o == !$past(pcs_sd_reg))
        else $error("restart or link drop mismatch");
    ack_once_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

endmodule // vlqm_top

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin failures++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end

module tb_top
    import vlqm_pkg::*;
;
    // ************************************************************
    // Stimulus and observation signals
    // ************************************************************
    typedef struct {logic [5:0] idx; logic we; logic [15:0] wd; logic [15:0] exp;} vlqm_row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] var_sum_i = 32'h0000_0000;
    logic var_new_i = 1'b0;
    logic link_100_ok_i = 1'b1;
    vlqm_dsp_t dsp_param_i = {5{16'h0100}};
    logic ack_o, irq_o, var_enable_o, var_restart_o, dsp_restart_o, link_drop_o;
    logic [31:0] dat_o;
    logic [1:0] var_timer_o;
    int failures = 0;
    int checks_done = 0;
    int dsp_cnt = 0;
    int drop_cnt = 0;
    logic [15:0] rd;
    vlqm_row_t rows[12] = '{
        '{6'h1B, 1'b0, 16'h0000, 16'h0000}, '{6'h1A, 1'b0, 16'h0000, 16'h0000},
        '{6'h1D, 1'b0, 16'h0000, 16'h0000}, '{6'h1A, 1'b1, 16'h0007, 16'h0000},
        '{6'h1A, 1'b0, 16'h0000, 16'h0007}, '{6'h1A, 1'b1, 16'hFFFF, 16'h0000},
        '{6'h1A, 1'b0, 16'h0000, 16'h000F}, '{6'h1D, 1'b1, 16'hFFFF, 16'h0000},
        '{6'h1D, 1'b0, 16'h0000, 16'hFC00}, '{6'h3F, 1'b1, 16'hFFFF, 16'h0000},
        '{6'h3F, 1'b0, 16'h0000, 16'h0000}, '{6'h1A, 1'b1, 16'h0001, 16'h0000}};

    always #5 clk_i = ~clk_i;

    vlqm_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .var_sum_i(var_sum_i),
        .var_new_i(var_new_i), .link_100_ok_i(link_100_ok_i), .dsp_param_i(dsp_param_i),
        .ack_o(ack_o), .dat_o(dat_o), .irq_o(irq_o), .var_enable_o(var_enable_o),
        .var_timer_o(var_timer_o), .var_restart_o(var_restart_o),
        .dsp_restart_o(dsp_restart_o), .link_drop_o(link_drop_o));

    // Pulse counters, so a one-cycle strobe is never missed between bus cycles
    always @(posedge clk_i) begin
        if (dsp_restart_o === 1'b1) dsp_cnt++;
        if (link_drop_o === 1'b1) drop_cnt++;
    end

    // ************************************************************
    // Bus and helper tasks
    // ************************************************************
    // Classic cycle: request held until ack is sampled, then released for a cycle
    task automatic wb(input logic [5:0] idx, input logic we, input logic [15:0] wd,
                      output logic [15:0] rdata);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= we;
        adr_i <= {idx, 2'b00};
        sel_i <= 4'h3;
        dat_i <= {16'h0000, wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        rdata = dat_o[15:0];
        if (n >= 50) begin
            failures++;
            $display("unexpected bus timeout at index %h", idx);
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic new_sum(input logic [31:0] v);
        @(posedge clk_i);
        var_sum_i <= v;
        var_new_i <= 1'b1;
        @(posedge clk_i);
        var_new_i <= 1'b0;
    endtask

    // Provoke a threshold violation, withdraw it, then read and re-read the monitor
    task automatic run_viol(input logic [5:0] idx, input logic [15:0] bad, good, exp_rd,
                            input logic exp_irq, input int exp_dsp, exp_drop);
        int c0;
        int l0;
        logic [15:0] r;
        c0 = dsp_cnt;
        l0 = drop_cnt;
        wb(idx, 1'b1, bad, r);
        repeat (3) @(posedge clk_i);
        `CHK("irq_o", exp_irq, irq_o)
        wb(idx, 1'b1, good, r);
        `CHK("dsp_restart_o pulses", exp_dsp, dsp_cnt - c0)
        `CHK("link_drop_o pulses", exp_drop, drop_cnt - l0)
        wb(VLQM_IDX_LQM_CTRL, 1'b0, 16'h0000, r);
        `CHK("monitor read", exp_rd, r)
        repeat (2) @(posedge clk_i);
        `CHK("irq_o after read", 1'b0, irq_o)
        wb(VLQM_IDX_LQM_CTRL, 1'b0, 16'h0000, r);
        `CHK("monitor reread", exp_rd & 16'hFC00, r)
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        int k;
        logic hi;
        logic [7:0] outs;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        outs = {ack_o, irq_o, var_enable_o, var_timer_o, var_restart_o, dsp_restart_o,
                link_drop_o};
        `CHK("outputs after reset", 8'h00, outs)
        // Register table rows: reset values, access kinds, unmapped place
        foreach (rows[i]) begin
            wb(rows[i].idx, rows[i].we, rows[i].wd, rd);
            if (!rows[i].we) `CHK("register row", rows[i].exp, rd)
        end
        `CHK("var_enable_o", 1'b1, var_enable_o)
        // Timer select reaches its pin and a control write restarts the computation
        wb(VLQM_IDX_VAR_CTRL, 1'b1, 16'h0005, rd);
        `CHK("var_restart_o", 1'b1, var_restart_o)
        `CHK("var_timer_o", 2'h2, var_timer_o)
        wb(VLQM_IDX_VAR_CTRL, 1'b1, 16'h0001, rd);
        $display("test register table done");
        // Variance readout: pointer reset by freeze, frozen value, auto clear
        new_sum(32'h1234_5678);
        wb(VLQM_IDX_VAR_CTRL, 1'b0, 16'h0000, rd);
        `CHK("ready after load", 16'h8001, rd)
        wb(VLQM_IDX_VAR_DATA, 1'b0, 16'h0000, rd);
        wb(VLQM_IDX_VAR_CTRL, 1'b1, 16'h0009, rd);
        new_sum(32'hAAAA_BBBB);
        wb(VLQM_IDX_VAR_CTRL, 1'b0, 16'h0000, rd);
        `CHK("frozen ctrl", 16'h8009, rd)
        wb(VLQM_IDX_VAR_DATA, 1'b0, 16'h0000, rd);
        `CHK("low half", 16'h5678, rd)
        wb(VLQM_IDX_VAR_DATA, 1'b0, 16'h0000, rd);
        `CHK("high half", 16'h1234, rd)
        wb(VLQM_IDX_VAR_CTRL, 1'b0, 16'h0000, rd);
        `CHK("ctrl after two reads", 16'h0001, rd)
        new_sum(32'hAAAA_BBBB);
        wb(VLQM_IDX_VAR_DATA, 1'b0, 16'h0000, rd);
        `CHK("load after thaw", 16'hBBBB, rd)
        $display("test variance done");
        // Thresholds at their extremes never flag
        wb(VLQM_IDX_INT_CTRL, 1'b1, 16'h0001, rd);
        wb(VLQM_IDX_LQM_CTRL, 1'b1, 16'hFC00, rd);
        @(posedge clk_i);
        dsp_param_i <= {5{16'hFFFF}};
        repeat (4) @(posedge clk_i);
        dsp_param_i <= {5{16'h0000}};
        repeat (4) @(posedge clk_i);
        dsp_param_i <= {5{16'h0100}};
        wb(VLQM_IDX_LQM_CTRL, 1'b0, 16'h0000, rd);
        `CHK("monitor at extremes", 16'hFC00, rd)
        `CHK("restarts at extremes", 0, dsp_cnt)
        $display("test extremes done");
        // Every threshold in turn, high bound at odd offsets
        for (int i = 0; i < 10; i++) begin
            k = 4 - i / 2;
            hi = (i % 2 == 0);
            run_viol(VLQM_IDX_THR_BASE + 6'(2 * k + int'(hi)), hi ? 16'h00FF : 16'h0101,
                     hi ? 16'hFFFF : 16'h0000,
                     16'hFC00 | {6'h00, VLQM_WARN_MASK & (10'h200 >> i)}, 1'b1, 1, 1);
        end
        $display("test threshold sweep done");
        // Interrupt disabled and signal detect option set
        wb(VLQM_IDX_PCS_CFG, 1'b1, 16'h0100, rd);
        wb(VLQM_IDX_INT_CTRL, 1'b1, 16'h0000, rd);
        run_viol(6'h2B, 16'h00FF, 16'hFFFF, 16'hFE00, 1'b0, 1, 0);
        wb(VLQM_IDX_INT_CTRL, 1'b1, 16'h0001, rd);
        $display("test masked and no drop done");
        // No valid link: monitor stays idle
        @(posedge clk_i);
        link_100_ok_i <= 1'b0;
        run_viol(6'h2B, 16'h00FF, 16'hFFFF, 16'hFC00, 1'b0, 0, 0);
        @(posedge clk_i);
        link_100_ok_i <= 1'b1;
        // Monitor enable clear with a good link
        wb(VLQM_IDX_LQM_CTRL, 1'b1, 16'h7C00, rd);
        run_viol(6'h2B, 16'h00FF, 16'hFFFF, 16'h7C00, 1'b0, 0, 0);
        $display("test monitor qualification done");
        // Reset in mid-run returns data and monitor to zero
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(VLQM_IDX_VAR_DATA, 1'b0, 16'h0000, rd);
        `CHK("data after reset", 16'h0000, rd)
        wb(VLQM_IDX_LQM_CTRL, 1'b0, 16'h0000, rd);
        `CHK("monitor after reset", 16'h0000, rd)
        $display("test second reset done");
        tally_and_finish();
    end

    // Whole run is well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        $display("unexpected watchdog expected %h seen %h", 1'b0, 1'b1);
        tally_and_finish();
    end
endmodule // tb_top
